// *** logic/cell_pkg.sv ***
// Purpose: Shared constants and types of the configurable logic cell
// Assumes: APB register slave, one 32-bit word per register
// Notes:   Gate select pairs run source 4 down to source 1, true above negated

package cell_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [11:0] ADDR_CONTROL_LOW  = 12'h000;
    localparam logic [11:0] ADDR_CONTROL_HIGH = 12'h004;
    localparam logic [11:0] ADDR_SOURCE_SEL   = 12'h008;
    localparam logic [11:0] ADDR_GATE_SEL_LO  = 12'h00c;
    localparam logic [11:0] ADDR_GATE_SEL_HI  = 12'h010;

    // Field positions of the low control register
    localparam int BIT_CELL_ENABLE  = 15;
    localparam int BIT_RISE_IRQ     = 11;
    localparam int BIT_FALL_IRQ     = 10;
    localparam int BIT_PIN_OE       = 7;
    localparam int BIT_OUT_STATE    = 6;
    localparam int BIT_OUT_INVERT   = 5;
    localparam int BIT_MODE_LO      = 0;
    // Each source select is 3 bits at a 4-bit pitch
    localparam int SEL_PITCH        = 4;
    // Each gate takes one byte of a gate select register
    localparam int GATE_PITCH       = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // ************************************************************
    // Logic function codes
    // ************************************************************
    localparam logic [2:0] MODE_AND_OR   = 3'h0;
    localparam logic [2:0] MODE_OR_XOR   = 3'h1;
    localparam logic [2:0] MODE_AND4     = 3'h2;
    localparam logic [2:0] MODE_SR_LATCH = 3'h3;
    localparam logic [2:0] MODE_DFF_SR   = 3'h4;
    localparam logic [2:0] MODE_DFF2_R   = 3'h5;
    localparam logic [2:0] MODE_JK_R     = 3'h6;
    localparam logic [2:0] MODE_LATCH_SR = 3'h7;

    // On-chip signals offered to the source multiplexers
    typedef struct packed {
        logic ext_input_a_pin;
        logic ext_input_b_pin;
        logic sys_cycle_clock;
        logic secondary_osc_clock;
        logic low_power_internal_clock;
        logic reference_clock_out;
        logic timer2_match;
        logic timer3_match;
        logic neighbour_cell_out;
        logic comparator1_out;
        logic comparator2_out;
        logic comparator3_out;
        logic uart_transmit;
        logic uart_receive;
        logic serial_data_out;
        logic serial_data_in;
        logic adc_done;
        logic dma0_irq;
        logic dma1_irq;
        logic capcomp1_event_flag;
        logic capcomp2_event_flag;
        logic capcomp3_event_flag;
        logic touch_adc_trigger;
    } sources_t;

    // Whole state of the cell
    typedef struct packed {
        logic             cell_enable;
        logic             rise_irq_enable;
        logic             fall_irq_enable;
        logic             pin_output_enable;
        logic             output_invert;
        logic [2:0]       mode;
        logic [3:0]       gate_invert;
        logic [3:0][2:0]  source_sel;
        logic [3:0][7:0]  gate_select;
        logic             q;
        logic             gate1_prev;
        logic             cell_out;
        logic             irq;
        logic [31:0]      prdata;
    } state_t;

endpackage : cell_pkg

// *** logic/configurable_logic_cell.sv ***
// Purpose: Configurable logic cell with four source muxes, four gates and eight functions
// Assumes: All source inputs synchronous to pclk; flip-flop modes 4-6 clocked on gate 1 rising
// Notes:   Registers over APB, zero wait states, read data captured in setup phase
//
// Operation
// - Four 3-bit muxes, eight codes each; code 5 of muxes 1 and 4 reads zero
// - Gates OR enabled true/inverted mux outputs
// - Per-gate invert bits 0 to 3
// - Enable bit 15 clear forces zero cell and pin outputs
// - Bit 11 enables rising-edge interrupt
// - Bit 10 enables falling-edge interrupt
// - Bit 7 connects result to pin
// - Read-only bit 6 shows output level
// - Bit 5 inverts the final output
// - Codes 0-3: AND-OR, OR-XOR, AND4, SR latch
// - Codes 4-7: DFF-SR, DFF2-R, JK-R, latch-SR
// - Mux 1 source map, bits 2-0
// - Mux 2 source map, bits 6-4
// - Mux 3 source map, bits 10-8
// - Mux 4 source map, bits 14-12
// - Instance sources: neighbour, own, matching channels
// - Unused bits read zero; reset clears all
// - Low gate select: gate 2 high, gate 1 low
// - High gate select: gate 4, gate 3; pairs ordered

module configurable_logic_cell #(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_WIDTH-1:0]   paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    // On-chip sources
    input  wire cell_pkg::sources_t      sources,
    // Cell results
    output logic                         cell_out,
    output logic                         cell_irq,
    output logic                         pin_out,
    output logic                         pin_oe_n
);

    // ************************************************************
    // Source selection and input gates
    // ************************************************************
    cell_pkg::state_t  st_reg;
    cell_pkg::state_t  st_next;
    logic [3:0][7:0]   cand;
    logic [3:0]        mux_out;
    logic [7:0]        pairs;
    logic [3:0]        gate;
    logic [11:0]       addr_lo;

    assign addr_lo = paddr[11:0];

    // Candidate lists per mux, unimplemented codes read zero
    always_comb begin
        cand[0] = {sources.timer3_match, sources.timer2_match, 1'b0,
                   sources.reference_clock_out, sources.low_power_internal_clock,
                   sources.secondary_osc_clock, sources.sys_cycle_clock,
                   sources.ext_input_a_pin};
        cand[1] = {sources.capcomp2_event_flag, sources.capcomp1_event_flag,
                   sources.dma0_irq, sources.adc_done, sources.uart_transmit,
                   sources.comparator1_out, sources.neighbour_cell_out,
                   sources.ext_input_b_pin};
        cand[2] = {sources.capcomp3_event_flag, sources.capcomp2_event_flag,
                   sources.dma1_irq, sources.uart_receive, sources.serial_data_out,
                   sources.comparator2_out, st_reg.cell_out,
                   sources.ext_input_a_pin};
        cand[3] = {sources.capcomp3_event_flag, sources.capcomp1_event_flag,
                   1'b0, sources.touch_adc_trigger, sources.serial_data_in,
                   sources.comparator3_out, sources.neighbour_cell_out,
                   sources.ext_input_b_pin};
    end

    // Each mux picks one candidate by its own select field
    for (genvar m = 0; m < 4; m++) begin : g_mux
        assign mux_out[m] = cand[m][st_reg.source_sel[m]];
    end

    // True above negated, source 4 down to source 1
    assign pairs = {mux_out[3], ~mux_out[3], mux_out[2], ~mux_out[2],
                    mux_out[1], ~mux_out[1], mux_out[0], ~mux_out[0]};

    // OR of enabled signals, empty selection yields zero, then optional invert
    for (genvar g = 0; g < 4; g++) begin : g_gate
        assign gate[g] = (|(st_reg.gate_select[g] & pairs))
                         ^ st_reg.gate_invert[g];
    end

    // ************************************************************
    // Logic function, register file and output stage
    // ************************************************************
    always_comb begin
        logic        rise;
        logic        logic_val;
        logic        q_n;
        logic        cell_val;
        logic        access;
        logic        setup;
        logic [31:0] rd;
        rise      = 1'b0;
        logic_val = 1'b0;
        q_n       = 1'b0;
        cell_val  = 1'b0;
        access    = psel & penable;
        setup     = psel & ~penable;
        rd        = cell_pkg::RESET_WORD;
        st_next   = st_reg;

        // Gate 1 acts as the storage clock
        rise = gate[0] & ~st_reg.gate1_prev;
        q_n  = st_reg.q;
        unique case (st_reg.mode)
            cell_pkg::MODE_AND_OR: begin
                logic_val = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            end
            cell_pkg::MODE_OR_XOR: begin
                logic_val = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            end
            cell_pkg::MODE_AND4: begin
                logic_val = &gate;
            end
            cell_pkg::MODE_SR_LATCH: begin
                // Set from gates 1/2, reset from gates 3/4, reset wins
                if (gate[2] | gate[3]) begin
                    q_n = 1'b0;
                end else if (gate[0] | gate[1]) begin
                    q_n = 1'b1;
                end
                logic_val = q_n;
            end
            cell_pkg::MODE_DFF_SR: begin
                // D from gate 2, reset gate 3, set gate 4
                if (gate[2]) begin
                    q_n = 1'b0;
                end else if (gate[3]) begin
                    q_n = 1'b1;
                end else if (rise) begin
                    q_n = gate[1];
                end
                logic_val = gate[2] ? 1'b0 : (gate[3] ? 1'b1 : st_reg.q);
            end
            cell_pkg::MODE_DFF2_R: begin
                // D is gate 2 AND gate 4, reset gate 3
                if (gate[2]) begin
                    q_n = 1'b0;
                end else if (rise) begin
                    q_n = gate[1] & gate[3];
                end
                logic_val = gate[2] ? 1'b0 : st_reg.q;
            end
            cell_pkg::MODE_JK_R: begin
                // J gate 2, K gate 4, reset gate 3
                if (gate[2]) begin
                    q_n = 1'b0;
                end else if (rise) begin
                    unique case ({gate[1], gate[3]})
                        2'b10: q_n = 1'b1;
                        2'b01: q_n = 1'b0;
                        2'b11: q_n = ~st_reg.q;
                        2'b00: q_n = st_reg.q;
                    endcase
                end
                logic_val = gate[2] ? 1'b0 : st_reg.q;
            end
            cell_pkg::MODE_LATCH_SR: begin
                // D gate 2, transparent while gate 1 high, reset gate 3, set gate 4
                if (gate[2]) begin
                    q_n = 1'b0;
                end else if (gate[3]) begin
                    q_n = 1'b1;
                end else if (gate[0]) begin
                    q_n = gate[1];
                end
                logic_val = q_n;
            end
        endcase

        // Disabled cell clears storage and drives zero
        if (st_reg.cell_enable) begin
            cell_val = logic_val ^ st_reg.output_invert;
            st_next.q = q_n;
        end else begin
            cell_val  = 1'b0;
            st_next.q = 1'b0;
        end
        st_next.gate1_prev = gate[0];
        st_next.cell_out   = cell_val;
        st_next.irq = (st_reg.rise_irq_enable & cell_val & ~st_reg.cell_out)
                    | (st_reg.fall_irq_enable & ~cell_val & st_reg.cell_out);

        // Read word assembled from fields, unused bits zero
        unique case (addr_lo)
            cell_pkg::ADDR_CONTROL_LOW: begin
                rd[cell_pkg::BIT_CELL_ENABLE] = st_reg.cell_enable;
                rd[cell_pkg::BIT_RISE_IRQ]    = st_reg.rise_irq_enable;
                rd[cell_pkg::BIT_FALL_IRQ]    = st_reg.fall_irq_enable;
                rd[cell_pkg::BIT_PIN_OE]      = st_reg.pin_output_enable;
                rd[cell_pkg::BIT_OUT_STATE]   = st_reg.cell_out;
                rd[cell_pkg::BIT_OUT_INVERT]  = st_reg.output_invert;
                rd[cell_pkg::BIT_MODE_LO +: 3] = st_reg.mode;
            end
            cell_pkg::ADDR_CONTROL_HIGH: begin
                rd[3:0] = st_reg.gate_invert;
            end
            cell_pkg::ADDR_SOURCE_SEL: begin
                for (int i = 0; i < 4; i++) begin
                    rd[i*cell_pkg::SEL_PITCH +: 3] = st_reg.source_sel[i];
                end
            end
            cell_pkg::ADDR_GATE_SEL_LO: begin
                rd[15:0] = {st_reg.gate_select[1], st_reg.gate_select[0]};
            end
            cell_pkg::ADDR_GATE_SEL_HI: begin
                rd[15:0] = {st_reg.gate_select[3], st_reg.gate_select[2]};
            end
            default: begin
                rd = cell_pkg::RESET_WORD;
            end
        endcase
        if (setup && !pwrite) begin
            st_next.prdata = rd;
        end

        // Writes take effect in the access phase; status bit ignores writes
        if (access && pwrite) begin
            unique case (addr_lo)
                cell_pkg::ADDR_CONTROL_LOW: begin
                    st_next.cell_enable       = pwdata[cell_pkg::BIT_CELL_ENABLE];
                    st_next.rise_irq_enable   = pwdata[cell_pkg::BIT_RISE_IRQ];
                    st_next.fall_irq_enable   = pwdata[cell_pkg::BIT_FALL_IRQ];
                    st_next.pin_output_enable = pwdata[cell_pkg::BIT_PIN_OE];
                    st_next.output_invert     = pwdata[cell_pkg::BIT_OUT_INVERT];
                    st_next.mode              = pwdata[cell_pkg::BIT_MODE_LO +: 3];
                end
                cell_pkg::ADDR_CONTROL_HIGH: begin
                    st_next.gate_invert = pwdata[3:0];
                end
                cell_pkg::ADDR_SOURCE_SEL: begin
                    for (int i = 0; i < 4; i++) begin
                        st_next.source_sel[i] = pwdata[i*cell_pkg::SEL_PITCH +: 3];
                    end
                end
                cell_pkg::ADDR_GATE_SEL_LO: begin
                    st_next.gate_select[0] = pwdata[0 +: cell_pkg::GATE_PITCH];
                    st_next.gate_select[1] = pwdata[cell_pkg::GATE_PITCH +: 8];
                end
                cell_pkg::ADDR_GATE_SEL_HI: begin
                    st_next.gate_select[2] = pwdata[0 +: cell_pkg::GATE_PITCH];
                    st_next.gate_select[3] = pwdata[cell_pkg::GATE_PITCH +: 8];
                end
                default: begin
                    st_next.mode = st_reg.mode;
                end
            endcase
        end
    end

    // State register, everything clears at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus handshake and cell outputs
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~((addr_lo == cell_pkg::ADDR_CONTROL_LOW)
                    | (addr_lo == cell_pkg::ADDR_CONTROL_HIGH)
                    | (addr_lo == cell_pkg::ADDR_SOURCE_SEL)
                    | (addr_lo == cell_pkg::ADDR_GATE_SEL_LO)
                    | (addr_lo == cell_pkg::ADDR_GATE_SEL_HI));
    assign prdata   = st_reg.prdata;
    assign cell_out = st_reg.cell_out;
    assign cell_irq = st_reg.irq;
    assign pin_out  = st_reg.cell_out & st_reg.pin_output_enable;
    assign pin_oe_n = ~st_reg.pin_output_enable;

endmodule : configurable_logic_cell

// *** verif/cell_source_model.sv ***
// Purpose: Model of the on-chip peripherals and pins feeding the cell
// Assumes: Peripheral flags are levels that change just after a clock edge
// Notes:   The bench states the wanted levels; the model offers them one edge later
module cell_source_model (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Wanted levels in, offered levels out
    input  wire cell_pkg::sources_t drive,
    output cell_pkg::sources_t      sources
);
    // Flags move only after an edge, as peripheral flops do
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sources <= '0;
        end else begin
            sources <= drive;
        end
    end
endmodule : cell_source_model

// *** verif/configurable_logic_cell_chk.sv ***
// Purpose: Port-level checks of the configurable logic cell
// Assumes: Zero-wait APB slave, registered cell outputs
// Notes:   Helper flops mirror the control bits that software writes
module configurable_logic_cell_chk #(
    parameter int ADDR_WIDTH = 12
) (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // APB
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Cell results
    input wire logic                  cell_out,
    input wire logic                  cell_irq,
    input wire logic                  pin_out,
    input wire logic                  pin_oe_n
);
    // ************************************************************
    // Mirror of the output controls
    // ************************************************************
    logic en_q, rise_q, fall_q, oe_q, acc, ctl;
    // Access phase, and access to the low control word
    assign acc = psel && penable;
    assign ctl = paddr == ADDR_WIDTH'(cell_pkg::ADDR_CONTROL_LOW);
    // Control bits land at the end of the write access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_q, rise_q, fall_q, oe_q} <= 4'h0;
        end else if (acc && pwrite && ctl) begin
            {en_q, rise_q, fall_q, oe_q} <= {pwdata[15], pwdata[11:10], pwdata[7]};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Register and bus checks
    a_zero_wait: assert property (acc |-> pready)
        else $error("access phase without ready");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_ctl_unused: assert property (acc && !pwrite && ctl |->
            {prdata[14:12], prdata[9:8], prdata[4:3]} == 7'h0)
        else $error("unused control bits read nonzero");
    a_status_mirror: assert property (acc && !pwrite && ctl |-> prdata[6] == $past(cell_out))
        else $error("status bit differs from cell output");
    a_unmapped_err: assert property (acc && paddr > ADDR_WIDTH'(cell_pkg::ADDR_GATE_SEL_HI) |-> pslverr)
        else $error("unmapped access without error");
    // Output and event checks
    a_disable_zero: assert property (!en_q && !$past(en_q) |-> !cell_out && !pin_out)
        else $error("disabled cell drives a one");
    // The event pulse is registered at the same edge as the new output level
    a_irq_gate: assert property (cell_irq |->
            (cell_out ? $past(rise_q) : $past(fall_q)) && cell_out != $past(cell_out))
        else $error("event pulse without enabled edge");
    a_rise_irq: assert property (cell_out && !$past(cell_out) && $past(rise_q) |-> cell_irq)
        else $error("rising edge lost its pulse");
    a_fall_irq: assert property (!cell_out && $past(cell_out) && $past(fall_q) |-> cell_irq)
        else $error("falling edge lost its pulse");
    a_pin_follows: assert property (pin_out == (cell_out && !pin_oe_n))
        else $error("pin level differs from cell output");
    a_pin_release: assert property (!oe_q |-> pin_oe_n)
        else $error("pin driven while disconnected");
endmodule : configurable_logic_cell_chk

bind configurable_logic_cell configurable_logic_cell_chk #(.ADDR_WIDTH(ADDR_WIDTH)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cell_out(cell_out), .cell_irq(cell_irq), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);

// *** verif/configurable_logic_cell_tb.sv ***
// Purpose: Self-checking bench of the configurable logic cell
// Assumes: Zero-wait APB slave; sources pass through the source model
// Notes:   Gates 1 to 4 carry pin A and comparators 1 to 3 unless a test remaps them
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module configurable_logic_cell_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic               cell_out, cell_irq, pin_out, pin_oe_n;
    logic [11:0]        paddr;
    logic [31:0]        pwdata, prdata, rd_data;
    cell_pkg::sources_t drive, sources;
    int                 err_count, compares, irq_n;
    localparam logic [11:0] AD [5] = '{cell_pkg::ADDR_CONTROL_LOW, cell_pkg::ADDR_CONTROL_HIGH,
        cell_pkg::ADDR_SOURCE_SEL, cell_pkg::ADDR_GATE_SEL_LO, cell_pkg::ADDR_GATE_SEL_HI};
    localparam logic [31:0] MK [5] = '{32'h0ca7, 32'h000f, 32'h7777, 32'h7fff, 32'h7fff};
    // Storage steps {expected, g4 g3 g2 g1} for modes 3 to 7
    localparam logic [4:0] SEQ [5][6] = '{'{5'h11, 5'h10, 5'h04, 5'h12, 5'h0a, 5'h00},
        '{5'h02, 5'h13, 5'h10, 5'h01, 5'h18, 5'h0c}, '{5'h03, 5'h0a, 5'h1b, 5'h1a, 5'h0e, 5'h00},
        '{5'h13, 5'h10, 5'h09, 5'h00, 5'h1b, 5'h04}, '{5'h13, 5'h12, 5'h10, 5'h01, 5'h18, 5'h0c}};
    // Source bit picked by each mux code; 1f means nothing external
    localparam logic [4:0] MAP [4][8] = '{'{5'h16, 5'h14, 5'h13, 5'h12, 5'h11, 5'h1f, 5'h10, 5'h0f},
        '{5'h15, 5'h0e, 5'h0d, 5'h0a, 5'h06, 5'h05, 5'h03, 5'h02},
        '{5'h16, 5'h1f, 5'h0c, 5'h08, 5'h09, 5'h04, 5'h02, 5'h01},
        '{5'h15, 5'h0e, 5'h0b, 5'h07, 5'h00, 5'h1f, 5'h03, 5'h01}};

    configurable_logic_cell #(.ADDR_WIDTH(12)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sources(sources),
        .cell_out(cell_out), .cell_irq(cell_irq), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    cell_source_model src (.pclk(pclk), .presetn(presetn), .drive(drive), .sources(sources));

    // Clock, event counter and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(negedge pclk) begin
        if (cell_irq === 1'b1) irq_n++;
    end
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end

    // One APB transfer; holds the request until ready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd_data, e)
    endtask : rd
    task automatic set_gates(input logic [3:0] g);
        @(posedge pclk);
        {drive.comparator3_out, drive.comparator2_out} <= g[3:2];
        {drive.comparator1_out, drive.ext_input_a_pin} <= g[1:0];
    endtask : set_gates
    task automatic see(input logic e);
        repeat (5) @(posedge pclk);
        #1;
        `CHK(cell_out, e)
    endtask : see
    task automatic report_and_stop();
        $display("TB: %0d compares, %0d errors", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Reset values, masks, read-only status and an unmapped word
    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            rd(AD[i], 32'h0);
            apb(1'b1, AD[i], 32'hffff_7fff);
            rd(AD[i], MK[i]);
            apb(1'b1, AD[i], 32'h0);
        end
        apb(1'b1, 12'h014, 32'h0000_ffff);
        `CHK(rd_err, 1'b1)
        rd(12'h014, 32'h0);
        $display("regs done");
    endtask : t_regs
    // Combinational modes over all gate levels, true, negated and inverted paths
    task automatic t_modes();
        logic [3:0] g;
        apb(1'b1, AD[2], 32'h2220);
        for (int p = 0; p < 3; p++) begin
            apb(1'b1, AD[3], p == 1 ? 32'h0401 : 32'h0802);
            apb(1'b1, AD[4], p == 1 ? 32'h4010 : 32'h8020);
            apb(1'b1, AD[1], p == 1 ? 32'hf : 32'h0);
            for (int m = 0; m < 3; m++) begin
                apb(1'b1, AD[0], 32'h8000 | (p == 2 ? 32'h20 : 32'h0) | 32'(m));
                for (int v = 0; v < 16; v++) begin
                    g = 4'(v);
                    set_gates(g);
                    see((p == 2) ^ (m == 0 ? (g[0] & g[1]) | (g[2] & g[3]) :
                        m == 1 ? (g[0] | g[1]) ^ (g[2] | g[3]) : &g));
                end
            end
        end
        $display("modes done");
    endtask : t_modes
    // Edge events, pin drive and disable with inverted polarity
    task automatic t_irq();
        int n0;
        apb(1'b1, AD[4], 32'h0);
        apb(1'b1, AD[0], 32'h8880);
        n0 = irq_n;
        set_gates(4'h3);
        see(1'b1);
        rd(AD[0], 32'h88c0);
        `CHK({pin_out, pin_oe_n}, 2'b10)
        set_gates(4'h0);
        see(1'b0);
        `CHK(irq_n - n0, 1)
        apb(1'b1, AD[0], 32'h8480);
        set_gates(4'h3);
        see(1'b1);
        set_gates(4'h0);
        see(1'b0);
        `CHK(irq_n - n0, 2)
        set_gates(4'h3);
        apb(1'b1, AD[0], 32'h0020);
        see(1'b0);
        `CHK({pin_out, pin_oe_n}, 2'b01)
        $display("irq done");
    endtask : t_irq
    // Every code of every source mux, through gate 1 alone
    task automatic t_map();
        logic [22:0] one;
        apb(1'b1, AD[0], 32'h8001);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, AD[3], 32'h2 << (2 * k));
            for (int c = 0; c < 8; c++) begin
                one = 23'h1 << MAP[k][c];
                apb(1'b1, AD[2], 32'(c) << (4 * k));
                @(posedge pclk);
                drive <= MAP[k][c] == 5'h1f ? '1 : one;
                see(MAP[k][c] != 5'h1f);
                @(posedge pclk);
                drive <= ~one;
                see(1'b0);
            end
        end
        $display("map done");
    endtask : t_map
    // Storage modes stepped through clock, data, set and reset gates
    task automatic t_store();
        for (int m = 3; m < 8; m++) begin
            set_gates(4'h0);
            apb(1'b1, AD[0], 32'h0);
            apb(1'b1, AD[0], 32'h8000 | 32'(m));
            for (int i = 0; i < 6; i++) begin
                set_gates(SEQ[m - 3][i][3:0]);
                see(SEQ[m - 3][i][4]);
            end
        end
        $display("storage done");
    endtask : t_store

    initial begin
        {psel, penable, pwrite, paddr, pwdata, drive} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_modes();
        t_store();
        t_irq();
        t_map();
        report_and_stop();
    end
endmodule : configurable_logic_cell_tb
